// ==== core/hsqr_edge_meter.sv ====
`timescale 1ns/1ps
`default_nettype none
module hsqr_edge_meter import hsqr_pkg::*; #(
	parameter int LOSS_CYC = HSQR_GPS_LOSS_CYC
) (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       sys_rst,
	// Pulse edges, one cycle each
	input  wire logic       int_pps,
	input  wire logic       gps_pps,
	// Measurement
	output hsqr_edge_t      meas,
	output logic            meas_stb
);

	// ****************************************
	// Time stamps
	// ****************************************
	logic [31:0] stamp_ff;    // Free-running cycle count
	logic [31:0] int_at_ff;   // Stamp of internal edge
	logic [31:0] gps_at_ff;   // Stamp of GPS edge
	logic        have_int_ff; // Internal edge waiting for its partner
	logic        have_gps_ff; // GPS edge waiting for its partner
	logic [31:0] loss_ff;     // Cycles since last GPS edge
	logic signed [31:0] offset_ff; // Last signed reading
	logic        missing_ff;  // No GPS edge lately

	// One driver per field: both halves come from their own flops
	assign meas = {missing_ff, offset_ff};

	wire logic        pair_done = have_int_ff & have_gps_ff;
	wire logic [31:0] diff_cyc  = gps_at_ff - int_at_ff;
	wire logic signed [47:0] diff_wide = 48'(signed'(diff_cyc)) * 48'(HSQR_TICKS_PER_CYC);
	// Saturate: a half-second gap in 0.1 ns does not fit 32 bits
	wire logic        too_pos   = ~diff_wide[47] & (|diff_wide[46:31]);
	wire logic        too_neg   = diff_wide[47] & ~(&diff_wide[46:31]);
	wire logic signed [31:0] diff_sat = too_pos ? 32'sh7fff_ffff :
		too_neg ? 32'sh8000_0000 : diff_wide[31:0];

	// Stamp edges; a pair yields one signed reading
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			stamp_ff    <= 32'h0;
			int_at_ff   <= 32'h0;
			gps_at_ff   <= 32'h0;
			have_int_ff <= 1'b0;
			have_gps_ff <= 1'b0;
			meas_stb    <= 1'b0;
			offset_ff   <= 32'sh0;
		end else begin
			stamp_ff <= stamp_ff + 32'h1;
			meas_stb <= pair_done;
			if (pair_done) begin
				offset_ff <= diff_sat;
			end
			if (int_pps) begin
				int_at_ff <= stamp_ff;
			end
			if (gps_pps) begin
				gps_at_ff <= stamp_ff;
			end
			have_int_ff <= int_pps | (have_int_ff & ~pair_done);
			have_gps_ff <= gps_pps | (have_gps_ff & ~pair_done);
		end
	end

	// Missing-pulse watchdog; nothing valid until a first GPS edge
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			loss_ff    <= 32'h0;
			missing_ff <= 1'b1;
		end else if (gps_pps) begin
			loss_ff    <= 32'h0;
			missing_ff <= 1'b0;
		end else if (loss_ff >= 32'(LOSS_CYC)) begin
			missing_ff <= 1'b1;
		end else begin
			loss_ff <= loss_ff + 32'h1;
		end
	end

endmodule : hsqr_edge_meter
`default_nettype wire

// ==== core/hsqr_pkg.sv ====
package hsqr_pkg;

	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam int          HSQR_ADDR_W       = 8;
	localparam logic [7:0]  HSQR_REG_CMD      = 8'h00; // Write-only command pulses
	localparam logic [7:0]  HSQR_REG_STATE    = 8'h04; // Sync state, one-hot
	localparam logic [7:0]  HSQR_REG_MERIT    = 8'h08; // Time merit code
	localparam logic [7:0]  HSQR_REG_OFFSET   = 8'h0c; // Edge offset, 0.1 ns units
	localparam logic [7:0]  HSQR_REG_DUR      = 8'h10; // Holdover duration, seconds
	localparam logic [7:0]  HSQR_REG_HSTAT    = 8'h14; // In-holdover and exceeded
	localparam logic [7:0]  HSQR_REG_LIMIT    = 8'h18; // Duration limit, seconds
	localparam logic [7:0]  HSQR_REG_WAIT     = 8'h1c; // Waiting reason
	localparam logic [7:0]  HSQR_REG_ERR      = 8'h20; // Error record, clear on read
	localparam logic [7:0]  HSQR_REG_OFS_MAX  = 8'h24; // Offset limit, 0.1 ns units

	// ****************************************
	// Field positions
	// ****************************************
	localparam int HSQR_CMD_MANUAL   = 0; // Enter manual holdover
	localparam int HSQR_CMD_RELEASE  = 1; // Release manual holdover
	localparam int HSQR_CMD_PRESET   = 2; // System preset
	localparam int HSQR_HST_HOLD     = 0; // In holdover
	localparam int HSQR_HST_EXCEED   = 1; // Limit exceeded

	// ****************************************
	// Reset and preset values
	// ****************************************
	localparam logic [31:0] HSQR_LIMIT_RST    = 32'h0001_5180; // 86400 s
	localparam logic [31:0] HSQR_OFS_MAX_RST  = 32'h0000_2710; // 1 us
	localparam logic [3:0]  HSQR_MERIT_MIN    = 4'h3;
	localparam logic [3:0]  HSQR_MERIT_MAX    = 4'h9;
	localparam logic [15:0] HSQR_ERR_NONE     = 16'h0000;
	localparam logic [15:0] HSQR_ERR_NOT_LOCK = 16'hff23; // -221
	localparam logic [15:0] HSQR_ERR_NO_DATA  = 16'hff1a; // -230

	// ****************************************
	// Timing
	// ****************************************
	localparam int          HSQR_CLK_PS       = 8000;  // Clock period in ps
	localparam int          HSQR_RES_PS       = 100;   // Offset resolution, 1E-10 s
	localparam int          HSQR_TICKS_PER_CYC = HSQR_CLK_PS / HSQR_RES_PS;
	localparam int          HSQR_GPS_LOSS_MS  = 2000;  // Missing GPS pulse after this
	localparam int          HSQR_GPS_LOSS_CYC =
		(HSQR_GPS_LOSS_MS * 1000) / HSQR_CLK_PS * 1000000;
	localparam int          HSQR_CONSIST_N    = 4;     // Seconds for a consistent verdict

	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [5:0] {
		HSQR_ST_OFF     = 6'h01,
		HSQR_ST_MANUAL  = 6'h02,
		HSQR_ST_WAIT    = 6'h04,
		HSQR_ST_RECOVER = 6'h08,
		HSQR_ST_LOCKED  = 6'h10,
		HSQR_ST_POWERUP = 6'h20
	} hsqr_state_t;

	typedef enum logic [1:0] {
		HSQR_WR_NONE = 2'h0,
		HSQR_WR_HARDWARE_WAIT_REASON = 2'h1,
		HSQR_WR_GPS  = 2'h2,
		HSQR_WR_OFS  = 2'h3
	} hsqr_wait_t;

	typedef struct packed {
		logic               missing; // No GPS pulse seen lately
		logic signed [31:0] offset;  // GPS edge minus internal edge, 0.1 ns
	} hsqr_edge_t;

endpackage : hsqr_pkg

// ==== core/hsqr_supervisor.sv ====
// The address map and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module hsqr_supervisor import hsqr_pkg::*; #(
	parameter int LOSS_CYC  = HSQR_GPS_LOSS_CYC,
	parameter int CONSIST_N = HSQR_CONSIST_N
) (
	// Clock and reset
	input  wire logic                   mclk,
	input  wire logic                   sys_rst,
	// AXI4-Lite write
	input  wire logic [HSQR_ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                   s_axi_awvalid,
	output logic                        s_axi_awready,
	input  wire logic [31:0]            s_axi_wdata,
	input  wire logic [3:0]             s_axi_wstrb,
	input  wire logic                   s_axi_wvalid,
	output logic                        s_axi_wready,
	output logic [1:0]                  s_axi_bresp,
	output logic                        s_axi_bvalid,
	input  wire logic                   s_axi_bready,
	// AXI4-Lite read
	input  wire logic [HSQR_ADDR_W-1:0] s_axi_araddr,
	input  wire logic                   s_axi_arvalid,
	output logic                        s_axi_arready,
	output logic [31:0]                 s_axi_rdata,
	output logic [1:0]                  s_axi_rresp,
	output logic                        s_axi_rvalid,
	input  wire logic                   s_axi_rready,
	// Timing inputs
	input  wire logic                   int_pps,
	input  wire logic                   gps_pps,
	input  wire logic [31:0]            time_err_ns,
	// Discipline loop status
	input  wire logic                   loop_locked,
	input  wire logic                   sats_present,
	input  wire logic                   hw_fault,
	input  wire logic                   diag_mode,
	// Status outputs
	output hsqr_state_t                 sync_state,
	output logic                        in_holdover,
	output logic                        dur_exceeded
);

	// ****************************************
	// Helpers
	// ****************************************

	// Decade of a nanosecond error, floored at the lowest code in use
	function automatic logic [3:0] merit_of(input logic [31:0] err);
		logic [31:0] step;
		logic [3:0]  code;
		step = 32'h1;
		code = 4'h0;
		for (int i = 0; i < 9; i++) begin
			if (err >= step) begin
				code = code + 4'h1;
			end
			step = 32'(step * 32'ha);
		end
		return (code < HSQR_MERIT_MIN) ? HSQR_MERIT_MIN : code;
	endfunction : merit_of

	// ****************************************
	// State
	// ****************************************
	hsqr_state_t     nxt_state;
	logic            first_lock_ff;  // Set on first lock, cleared by preset
	logic [31:0]     dur_ff;         // Holdover seconds
	logic [31:0]     limit_ff;       // Holdover duration limit
	logic [31:0]     ofs_max_ff;     // Offset limit
	logic [3:0]      merit_ff;       // Time merit code
	logic [15:0]     err_ff;         // Last error code
	logic [3:0]      bad_run_ff;     // Consecutive readings over the limit
	logic [3:0]      good_run_ff;    // Consecutive readings within it
	logic            ofs_bad_ff;     // Offset consistently over limit
	hsqr_edge_t      edge_meas;
	logic            edge_stb;

	// ****************************************
	// Edge offset measurement
	// ****************************************
	hsqr_edge_meter #(
		.LOSS_CYC (LOSS_CYC)
	) u_meter (
		.mclk     (mclk),
		.sys_rst  (sys_rst),
		.int_pps  (int_pps),
		.gps_pps  (gps_pps),
		.meas     (edge_meas),
		.meas_stb (edge_stb)
	);

	// ****************************************
	// Bus decode
	// ****************************************
	logic                   aw_have_ff;  // Write address held
	logic                   w_have_ff;   // Write data held
	logic [HSQR_ADDR_W-1:0] aw_addr_ff;
	logic [31:0]            w_data_ff;
	logic [3:0]             w_strb_ff;

	wire logic wr_go   = aw_have_ff & w_have_ff & ~s_axi_bvalid;
	wire logic wr_cmd  = wr_go & (aw_addr_ff == HSQR_REG_CMD) & w_strb_ff[0];
	wire logic wr_lim  = wr_go & (aw_addr_ff == HSQR_REG_LIMIT);
	wire logic wr_omax = wr_go & (aw_addr_ff == HSQR_REG_OFS_MAX);
	wire logic wr_ok   = (aw_addr_ff == HSQR_REG_CMD) | (aw_addr_ff == HSQR_REG_LIMIT) |
		(aw_addr_ff == HSQR_REG_OFS_MAX);
	wire logic rd_go   = s_axi_arvalid & s_axi_arready;

	// Command pulses
	wire logic cmd_manual  = wr_cmd & w_data_ff[HSQR_CMD_MANUAL];
	wire logic cmd_release = wr_cmd & w_data_ff[HSQR_CMD_RELEASE];
	wire logic cmd_preset  = wr_cmd & w_data_ff[HSQR_CMD_PRESET];

	// ****************************************
	// Holdover conditions
	// ****************************************
	wire logic hold_now  = (sync_state == HSQR_ST_MANUAL) | (sync_state == HSQR_ST_WAIT) |
		(sync_state == HSQR_ST_RECOVER);
	wire logic manual_ok = first_lock_ff & (sync_state != HSQR_ST_OFF) &
		(sync_state != HSQR_ST_MANUAL);
	wire logic manual_rej = cmd_manual & ~first_lock_ff;
	// Priority: hardware, then satellites, then offset limit
	wire hsqr_wait_t reason = hw_fault ? HSQR_WR_HARDWARE_WAIT_REASON :
		~sats_present ? HSQR_WR_GPS :
		ofs_bad_ff ? HSQR_WR_OFS : HSQR_WR_NONE;
	wire logic must_wait = (reason != HSQR_WR_NONE);
	// Only the waiting state shows a reason; manual holdover shows none
	wire hsqr_wait_t wait_rpt = (sync_state == HSQR_ST_WAIT) ? reason : HSQR_WR_NONE;
	wire logic ofs_over = edge_meas.offset > signed'(ofs_max_ff) |
		edge_meas.offset < -signed'(ofs_max_ff);
	wire logic rd_ofs_err = rd_go & (s_axi_araddr == HSQR_REG_OFFSET) & edge_meas.missing;

	// ****************************************
	// Synchronisation state machine
	// ****************************************

	// Next state; manual holdover leaves through release, preset or diagnostic mode
	always_comb begin
		nxt_state = sync_state;
		case (sync_state)
			HSQR_ST_OFF: begin
				if (!diag_mode) nxt_state = HSQR_ST_POWERUP;
			end
			HSQR_ST_POWERUP: begin
				if (loop_locked) nxt_state = HSQR_ST_LOCKED;
			end
			HSQR_ST_LOCKED: begin
				if (must_wait) nxt_state = HSQR_ST_WAIT;
			end
			HSQR_ST_MANUAL: begin
				if (cmd_release) nxt_state = HSQR_ST_RECOVER;
			end
			HSQR_ST_WAIT: begin
				if (!must_wait) nxt_state = HSQR_ST_RECOVER;
			end
			HSQR_ST_RECOVER: begin
				if (must_wait) nxt_state = HSQR_ST_WAIT;
				else if (loop_locked) nxt_state = HSQR_ST_LOCKED;
			end
			default: nxt_state = HSQR_ST_POWERUP;
		endcase
		if (cmd_manual && manual_ok) nxt_state = HSQR_ST_MANUAL;
		if (diag_mode) nxt_state = HSQR_ST_OFF;
		if (cmd_preset) nxt_state = HSQR_ST_POWERUP;
	end

	// State register and first-lock memory
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			sync_state    <= HSQR_ST_POWERUP;
			first_lock_ff <= 1'b0;
		end else begin
			sync_state <= nxt_state;
			if (cmd_preset) first_lock_ff <= 1'b0;
			else if (nxt_state == HSQR_ST_LOCKED) first_lock_ff <= 1'b1;
		end
	end

	// ****************************************
	// Holdover duration and limit
	// ****************************************

	// Count runs from zero on entry and freezes on exit
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			dur_ff       <= 32'h0;
			in_holdover  <= 1'b0;
			dur_exceeded <= 1'b0;
		end else if (cmd_preset) begin
			dur_ff       <= 32'h0;
			in_holdover  <= 1'b0;
			dur_exceeded <= 1'b0;
		end else begin
			in_holdover <= hold_now;
			if (hold_now && !in_holdover) dur_ff <= 32'h0;
			else if (hold_now && int_pps) dur_ff <= dur_ff + 32'h1;
			dur_exceeded <= hold_now & (dur_ff > limit_ff);
		end
	end

	// Limit registers; the duration limit is whole seconds only, so no fraction is kept
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			limit_ff   <= HSQR_LIMIT_RST;
			ofs_max_ff <= HSQR_OFS_MAX_RST;
		end else if (cmd_preset) begin
			limit_ff   <= HSQR_LIMIT_RST;
		end else begin
			if (wr_lim) limit_ff <= w_data_ff;
			if (wr_omax) ofs_max_ff <= w_data_ff;
		end
	end

	// ****************************************
	// Offset verdict and merit
	// ****************************************

	// A verdict flips only after a run of like readings
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			bad_run_ff  <= 4'h0;
			good_run_ff <= 4'h0;
			ofs_bad_ff  <= 1'b0;
			merit_ff    <= HSQR_MERIT_MAX;
		end else begin
			merit_ff <= merit_of(time_err_ns);
			if (edge_stb) begin
				bad_run_ff  <= ofs_over ? bad_run_ff + 4'h1 : 4'h0;
				good_run_ff <= ofs_over ? 4'h0 : good_run_ff + 4'h1;
				if (ofs_over && bad_run_ff >= 4'(CONSIST_N - 1)) ofs_bad_ff <= 1'b1;
				if (!ofs_over && good_run_ff >= 4'(CONSIST_N - 1)) ofs_bad_ff <= 1'b0;
			end
		end
	end

	// ****************************************
	// Error record
	// ****************************************

	// A new error beats the clear from reading the record
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			err_ff <= HSQR_ERR_NONE;
		end else if (manual_rej) begin
			err_ff <= HSQR_ERR_NOT_LOCK;
		end else if (rd_ofs_err) begin
			err_ff <= HSQR_ERR_NO_DATA;
		end else if (cmd_preset || (rd_go && s_axi_araddr == HSQR_REG_ERR)) begin
			err_ff <= HSQR_ERR_NONE;
		end
	end

	// ****************************************
	// AXI4-Lite write channel
	// ****************************************
	assign s_axi_awready = ~aw_have_ff;
	assign s_axi_wready  = ~w_have_ff;

	// Address and data taken in either order, answered together
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			aw_have_ff   <= 1'b0;
			w_have_ff    <= 1'b0;
			aw_addr_ff   <= '0;
			w_data_ff    <= 32'h0;
			w_strb_ff    <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= 2'h0;
		end else begin
			if (s_axi_awvalid && !aw_have_ff) begin
				aw_have_ff <= 1'b1;
				aw_addr_ff <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_have_ff) begin
				w_have_ff <= 1'b1;
				w_data_ff <= s_axi_wdata;
				w_strb_ff <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_have_ff   <= 1'b0;
				w_have_ff    <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ****************************************
	// AXI4-Lite read channel
	// ****************************************
	wire logic [HSQR_ADDR_W-1:0] ra = s_axi_araddr;
	wire logic [31:0] rd_mux =
		(ra == HSQR_REG_STATE)   ? {26'h0, sync_state} :
		(ra == HSQR_REG_MERIT)   ? {28'h0, merit_ff} :
		(ra == HSQR_REG_OFFSET)  ? (edge_meas.missing ? 32'h0 : edge_meas.offset) :
		(ra == HSQR_REG_DUR)     ? dur_ff :
		(ra == HSQR_REG_HSTAT)   ? {30'h0, dur_exceeded, in_holdover} :
		(ra == HSQR_REG_LIMIT)   ? limit_ff :
		(ra == HSQR_REG_WAIT)    ? {30'h0, wait_rpt} :
		(ra == HSQR_REG_ERR)     ? {{16{err_ff[15]}}, err_ff} :
		(ra == HSQR_REG_OFS_MAX) ? ofs_max_ff : 32'h0;
	wire logic rd_known = (ra == HSQR_REG_STATE) | (ra == HSQR_REG_MERIT) |
		(ra == HSQR_REG_OFFSET) | (ra == HSQR_REG_DUR) | (ra == HSQR_REG_HSTAT) |
		(ra == HSQR_REG_LIMIT) | (ra == HSQR_REG_WAIT) | (ra == HSQR_REG_ERR) |
		(ra == HSQR_REG_OFS_MAX);

	assign s_axi_arready = ~s_axi_rvalid;

	// One read at a time; missing offset answers with a slave error
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0;
			s_axi_rresp  <= 2'h0;
		end else if (rd_go) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_mux;
			s_axi_rresp  <= (rd_known && !rd_ofs_err) ? 2'h0 : 2'h2;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule : hsqr_supervisor
`default_nettype wire

// ==== sim/hsqr_pps_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Pulse source standing in for the oscillator and the GPS receiver
module hsqr_pps_model #(
	parameter int PER = 40, // Cycles per simulated second, kept short
	parameter int DLY = 2   // GPS edge lag behind the internal edge
) (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic sys_rst,
	// GPS pulse present
	input  wire logic gps_en,
	// Pulse edges
	output logic      int_pps,
	output logic      gps_pps
);
	int cnt_ff; // Position within the second

	// Both pulses last one cycle; GPS one is absent while disabled
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) begin
			cnt_ff  <= 0;
			int_pps <= 1'b0;
			gps_pps <= 1'b0;
		end else begin
			cnt_ff  <= (cnt_ff == PER - 1) ? 0 : cnt_ff + 1;
			int_pps <= (cnt_ff == 0);
			gps_pps <= gps_en && (cnt_ff == DLY);
		end
	end
endmodule : hsqr_pps_model
`default_nettype wire

// ==== sim/hsqr_sup_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module hsqr_sup_assertions import hsqr_pkg::*; (
	// Clock and reset
	input wire logic        mclk,
	input wire logic        sys_rst,
	// Bus handshakes
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	// Status
	input wire logic        diag_mode,
	input wire hsqr_state_t sync_state,
	input wire logic        in_holdover,
	input wire logic        dur_exceeded
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	logic [2:0] since_wr_ff; // Cycles since a data beat, saturating

	// Only a command write or diagnostic mode may end manual holdover, so track how recent a write was
	always_ff @(posedge mclk or posedge sys_rst) begin
		if (sys_rst) since_wr_ff <= 3'h7;
		else if (s_axi_wvalid && s_axi_wready) since_wr_ff <= 3'h0;
		else if (since_wr_ff != 3'h7) since_wr_ff <= since_wr_ff + 3'h1;
	end

	state_onehot_a: assert property ($onehot(sync_state))
		else $error("sync state not one-hot");
	idle_no_exceed_a: assert property (!in_holdover && !$past(in_holdover) |-> !dur_exceeded)
		else $error("exceeded outside holdover");
	exceed_rise_a: assert property ($rose(dur_exceeded) |-> in_holdover || $past(in_holdover))
		else $error("exceeded rose without holdover");
	manual_hold_a: assert property (sync_state == HSQR_ST_MANUAL
		&& $past(sync_state) == HSQR_ST_MANUAL |-> in_holdover)
		else $error("manual state without holdover flag");
	wait_hold_a: assert property (sync_state == HSQR_ST_WAIT
		&& $past(sync_state) == HSQR_ST_WAIT |-> in_holdover)
		else $error("waiting state without holdover flag");
	lock_idle_a: assert property (sync_state == HSQR_ST_LOCKED
		&& $past(sync_state) == HSQR_ST_LOCKED |-> !in_holdover)
		else $error("locked state with holdover flag");
	powerup_idle_a: assert property (sync_state == HSQR_ST_POWERUP
		&& $past(sync_state) == HSQR_ST_POWERUP |-> !in_holdover && !dur_exceeded)
		else $error("powerup state with holdover flags");
	manual_exit_a: assert property ($past(sync_state) == HSQR_ST_MANUAL
		&& sync_state != HSQR_ST_MANUAL
		|-> since_wr_ff < 3'h5 || diag_mode || $past(diag_mode))
		else $error("manual holdover left without command");
	diag_off_a: assert property ($rose(diag_mode) |-> ##[1:2] sync_state == HSQR_ST_OFF)
		else $error("diagnostic mode did not force off");
	read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered next cycle");

	cover property (sync_state == HSQR_ST_MANUAL);
	cover property (sync_state == HSQR_ST_WAIT);
	cover property ($rose(dur_exceeded));
endmodule : hsqr_sup_assertions
bind hsqr_supervisor hsqr_sup_assertions u_chk (.mclk, .sys_rst, .s_axi_wvalid, .s_axi_wready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .diag_mode, .sync_state, .in_holdover,
	.dur_exceeded);
`default_nettype wire

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_top import hsqr_pkg::*; ;
	logic mclk = 1'b0, sys_rst = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, time_err_ns = 32'h0, s_axi_rdata, rd, d0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, gps_en = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic int_pps, gps_pps, in_holdover, dur_exceeded;
	logic loop_locked = 1'b0, sats_present = 1'b1, hw_fault = 1'b0, diag_mode = 1'b0;
	hsqr_state_t sync_state;
	int fails = 0, n_checks = 0;
	// Error levels in ns and the merit code each must give
	logic [31:0] errs [8] = '{32'h0, 32'd999, 32'd1000, 32'd99999, 32'd100000,
		32'd99999999, 32'd100000000, 32'hffffffff};
	logic [31:0] codes [8] = '{32'h3, 32'h3, 32'h4, 32'h5, 32'h6, 32'h8, 32'h9, 32'h9};

	always #4 mclk = ~mclk;

	// Short second and fast loss detection keep the run brief
	hsqr_pps_model #(.PER(40), .DLY(2)) u_pps (.mclk, .sys_rst, .gps_en, .int_pps, .gps_pps);
	hsqr_supervisor #(.LOSS_CYC(200), .CONSIST_N(2)) dut (.mclk, .sys_rst, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .int_pps, .gps_pps, .time_err_ns, .loop_locked, .sats_present,
		.hw_fault, .diag_mode, .sync_state, .in_holdover, .dur_exceeded);

	task automatic final_report;
		if (fails == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : final_report

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic hang;
		fails++;
		$display("ERROR %0t: wait ran out", $time);
		final_report();
	endtask : hang

	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge mclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (i == 50) hang();
	endtask : wr

	task automatic rdr(input logic [7:0] a);
		int i;
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge mclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		rd = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (i == 50) hang();
	endtask : rdr

	// State changes wait on whole seconds, so poll under a bound
	task automatic poll(input logic [7:0] a, input logic [31:0] e);
		for (int k = 0; k < 80; k++) begin
			rdr(a);
			if (rd === e) break;
		end
		chk(rd, e);
		if (rd !== e) final_report();
	endtask : poll

	task automatic ticks(input int n);
		for (int i = 0; i < 500 && n > 0; i++) begin
			@(posedge mclk);
			if (int_pps) n--;
		end
		if (n > 0) hang();
	endtask : ticks

	initial begin
		repeat (8) @(posedge mclk);
		sys_rst <= 1'b0;
		rdr(HSQR_REG_STATE); chk(rd, 32'h20);
		rdr(HSQR_REG_DUR); chk(rd, 32'h0);
		rdr(HSQR_REG_HSTAT); chk(rd, 32'h0);
		rdr(HSQR_REG_LIMIT); chk(rd, HSQR_LIMIT_RST);
		rdr(HSQR_REG_OFFSET); chk({30'h0, rs}, 32'h2);
		rdr(HSQR_REG_ERR); chk(rd, 32'hffffff1a);
		rdr(HSQR_REG_ERR); chk(rd, 32'h0);
		wr(HSQR_REG_CMD, 32'h1);
		rdr(HSQR_REG_ERR); chk(rd, 32'hffffff23);
		rdr(HSQR_REG_STATE); chk(rd, 32'h20);
		for (int k = 0; k < 8; k++) begin
			time_err_ns <= errs[k];
			rdr(HSQR_REG_MERIT); chk(rd, codes[k]);
		end
		gps_en <= 1'b1;
		loop_locked <= 1'b1;
		poll(HSQR_REG_STATE, 32'h10);
		poll(HSQR_REG_OFFSET, 32'd160);
		wr(HSQR_REG_LIMIT, 32'd2);
		rdr(HSQR_REG_LIMIT); chk(rd, 32'd2);
		ticks(1);
		wr(HSQR_REG_CMD, 32'h1);
		rdr(HSQR_REG_STATE); chk(rd, 32'h2);
		ticks(2);
		rdr(HSQR_REG_DUR); chk(rd, 32'd2);
		rdr(HSQR_REG_HSTAT); chk(rd, 32'h1);
		ticks(1);
		rdr(HSQR_REG_DUR); chk(rd, 32'd3);
		rdr(HSQR_REG_HSTAT); chk(rd, 32'h3);
		chk({30'h0, dur_exceeded, in_holdover}, 32'h3);
		hw_fault <= 1'b1;
		rdr(HSQR_REG_WAIT); chk(rd, 32'h0);
		rdr(HSQR_REG_STATE); chk(rd, 32'h2);
		hw_fault <= 1'b0;
		loop_locked <= 1'b0;
		wr(HSQR_REG_CMD, 32'h2);
		rdr(HSQR_REG_STATE); chk(rd, 32'h8);
		chk({26'h0, sync_state}, 32'h8);
		chk({31'h0, in_holdover}, 32'h1);
		loop_locked <= 1'b1;
		poll(HSQR_REG_STATE, 32'h10);
		rdr(HSQR_REG_HSTAT); chk(rd, 32'h0);
		rdr(HSQR_REG_DUR);
		d0 = rd;
		ticks(1);
		rdr(HSQR_REG_DUR); chk(rd, d0);
		hw_fault <= 1'b1;
		sats_present <= 1'b0;
		poll(HSQR_REG_STATE, 32'h4);
		rdr(HSQR_REG_WAIT); chk(rd, 32'h1);
		wr(HSQR_REG_CMD, 32'h2);
		rdr(HSQR_REG_STATE); chk(rd, 32'h4);
		hw_fault <= 1'b0;
		poll(HSQR_REG_WAIT, 32'h2);
		sats_present <= 1'b1;
		poll(HSQR_REG_STATE, 32'h10);
		wr(HSQR_REG_OFS_MAX, 32'd100);
		poll(HSQR_REG_WAIT, 32'h3);
		wr(HSQR_REG_OFS_MAX, HSQR_OFS_MAX_RST);
		poll(HSQR_REG_STATE, 32'h10);
		diag_mode <= 1'b1;
		poll(HSQR_REG_STATE, 32'h1);
		diag_mode <= 1'b0;
		poll(HSQR_REG_STATE, 32'h10);
		wr(HSQR_REG_CMD, 32'h1);
		ticks(1);
		loop_locked <= 1'b0;
		wr(HSQR_REG_CMD, 32'h4);
		rdr(HSQR_REG_STATE); chk(rd, 32'h20);
		rdr(HSQR_REG_DUR); chk(rd, 32'h0);
		rdr(HSQR_REG_HSTAT); chk(rd, 32'h0);
		chk({30'h0, dur_exceeded, in_holdover}, 32'h0);
		rdr(HSQR_REG_LIMIT); chk(rd, HSQR_LIMIT_RST);
		wr(HSQR_REG_CMD, 32'h1);
		rdr(HSQR_REG_ERR); chk(rd, 32'hffffff23);
		rdr(8'h30); chk({rs, rd[29:0]}, 32'h80000000);
		wr(8'h30, 32'h0); chk({30'h0, rs}, 32'h2);
		final_report();
	end
endmodule : tb_top
`default_nettype wire
